// >>> src/crf_pkg.sv
package crf_pkg;

    // register byte offsets
    localparam logic [7:0] CRF_OFS_FIFO0   = 8'h0C;
    localparam logic [7:0] CRF_OFS_FIFO1   = 8'h10;
    localparam logic [7:0] CRF_OFS_IRQ_EN  = 8'h14;

    // fifo status field positions
    localparam int CRF_B_PEND_LO   = 0;
    localparam int CRF_B_FULL      = 3;
    localparam int CRF_B_OVR       = 4;
    localparam int CRF_B_REL       = 5;

    // irq enable field positions
    localparam int CRF_B_TXE       = 0;
    localparam int CRF_B_F0_PEND   = 1;
    localparam int CRF_B_F0_FULL   = 2;
    localparam int CRF_B_F0_OVR    = 3;
    localparam int CRF_B_F1_PEND   = 4;
    localparam int CRF_B_F1_FULL   = 5;
    localparam int CRF_B_F1_OVR    = 6;

    // writable irq enable bits: 17:15, 11:8, 6:0
    localparam logic [31:0] CRF_IRQ_EN_MASK = 32'h0003_8F7F;

    // reset values and limits
    localparam logic [31:0] CRF_IRQ_EN_RST  = 32'h0000_0000;
    localparam logic [1:0]  CRF_PEND_RST    = 2'h0;
    localparam logic [1:0]  CRF_PEND_MAX    = 2'h3;

endpackage : crf_pkg

// >>> src/crf_fifo_ctl.sv
`timescale 1ns/1ps
`default_nettype none

// one receive fifo: count, full, overrun, release handshake
module crf_fifo_ctl
    import crf_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // receive engine side
    input  wire logic       store,
    // software side
    input  wire logic       rel_set,
    input  wire logic       full_clr,
    input  wire logic       ovr_clr,
    // state
    output logic [1:0]      pend_count,
    output logic            full_flag,
    output logic            ovr_flag,
    output logic            rel_req,
    output logic            rel_done
);

    typedef struct packed {
        logic [1:0] pend;
        logic       full;
        logic       ovr;
        logic       rel;
    } crf_fifo_s;

    crf_fifo_s s_q;
    crf_fifo_s s_d;
    logic      take;
    logic      drop;

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        s_d  = s_q;
        drop = s_q.rel && (s_q.pend != CRF_PEND_RST);
        // a store beside a free still finds room, so a full fifo keeps it
        take = store && ((s_q.pend != CRF_PEND_MAX) || drop);
        // request set only while a message waits
        if (rel_set && (s_q.pend != CRF_PEND_RST))
        begin
            s_d.rel = 1'b1;
        end
        // free mailbox then self-clear request
        if (drop)
        begin
            s_d.rel = 1'b0;
        end
        if (take && !drop)
        begin
            s_d.pend = s_q.pend + 2'h1;
        end
        else if (drop && !take)
        begin
            s_d.pend = s_q.pend - 2'h1;
        end
        // sticky flags, set wins over clear
        if (full_clr)
        begin
            s_d.full = 1'b0;
        end
        if (take && !drop && (s_q.pend == 2'h2))
        begin
            s_d.full = 1'b1;
        end
        if (ovr_clr)
        begin
            s_d.ovr = 1'b0;
        end
        if (store && !drop && (s_q.pend == CRF_PEND_MAX))
        begin
            s_d.ovr = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign pend_count = s_q.pend;
    assign full_flag  = s_q.full;
    assign ovr_flag   = s_q.ovr;
    assign rel_req    = s_q.rel;
    assign rel_done   = drop;

endmodule : crf_fifo_ctl

`default_nettype wire

// >>> src/crf_irq.sv
`timescale 1ns/1ps
`default_nettype none

// registered per-fifo interrupt request
module crf_irq
    import crf_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // conditions and enables
    input  wire logic [2:0] cond,
    input  wire logic [2:0] en,
    // request
    output logic            irq
);

    typedef struct packed {
        logic irq;
    } crf_irq_s;

    crf_irq_s s_q;
    crf_irq_s s_d;

    ////////////////////////////////////////////////////////////////////////////
    // or of enabled conditions
    always_comb
    begin
        s_d     = s_q;
        s_d.irq = |(cond & en);
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign irq = s_q.irq;

endmodule : crf_irq

`default_nettype wire

// >>> src/crf_top.sv
// Functional notes
// - a release request on a fifo holding a message discards its oldest message; empty ignores it.
// - the release request bit clears by itself once the mailbox is freed.
// - a stored message arriving while three are held and none is freed in that cycle sets the sticky overrun flag, write one clears.
// - the full flag sets when the count reaches three and clears by writing one.
// - the two-bit pending count rises on store and falls on release.
// - status bits 31:6 and bit 2 read as zero.
// - fifo 1 behaves exactly like fifo 0 with its own status register.
// - the interrupt enable register resets to zero and holds all enable bits.
// - a fifo requests interrupt, one cycle later, while its pending, full or overrun condition is set and that condition's own enable bit is set.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module crf_top
    import crf_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata,
    // receive engine stores, one per fifo
    input  wire logic [1:0]  rx_store,
    // fifo interrupts and status
    output logic [1:0]       fifo_irq,
    output logic [1:0]       release_done
);

    typedef struct packed {
        logic [31:0] ien;
        logic [31:0] rdata;
    } crf_top_s;

    crf_top_s    s_q;
    crf_top_s    s_d;
    logic [1:0]  pend [2];
    logic [1:0]  full;
    logic [1:0]  ovr;
    logic [1:0]  rel;
    logic [31:0] stat [2];

    ////////////////////////////////////////////////////////////////////////////
    // the two receive fifos
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_fifo
            logic hit;
            logic wr_hit;
            assign hit    = (addr == (g == 0 ? CRF_OFS_FIFO0 : CRF_OFS_FIFO1));
            assign wr_hit = wr && hit;

            crf_fifo_ctl u_fifo (
                .clk        (clk),
                .nrst       (nrst),
                .store      (rx_store[g]),
                .rel_set    (wr_hit && wdata[CRF_B_REL]),
                .full_clr   (wr_hit && wdata[CRF_B_FULL]),
                .ovr_clr    (wr_hit && wdata[CRF_B_OVR]),
                .pend_count (pend[g]),
                .full_flag  (full[g]),
                .ovr_flag   (ovr[g]),
                .rel_req    (rel[g]),
                .rel_done   (release_done[g])
            );

            // status word, unused bits zero
            assign stat[g] = {26'h0, rel[g], ovr[g], full[g], 1'b0, pend[g]};

            crf_irq u_irq (
                .clk  (clk),
                .nrst (nrst),
                .cond ({ovr[g], full[g], (pend[g] != CRF_PEND_RST)}),
                .en   (s_q.ien[CRF_B_F0_PEND + 3*g +: 3]),
                .irq  (fifo_irq[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // register writes and read mux
    always_comb
    begin
        s_d       = s_q;
        s_d.rdata = 32'h0000_0000;
        if (wr && (addr == CRF_OFS_IRQ_EN))
        begin
            s_d.ien = wdata & CRF_IRQ_EN_MASK;
        end
        if (rd)
        begin
            case (addr)
                CRF_OFS_FIFO0:  s_d.rdata = stat[0];
                CRF_OFS_FIFO1:  s_d.rdata = stat[1];
                CRF_OFS_IRQ_EN: s_d.rdata = s_q.ien;
                default:        s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_q.ien   <= CRF_IRQ_EN_RST;
            s_q.rdata <= 32'h0000_0000;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;

endmodule : crf_top

`default_nettype wire

// >>> bench/crf_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
// stand-in receive engine: one store pulse per filtered message
module crf_rx_model
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // bench requests and store pulses
    input  wire logic [1:0] msg_rdy,
    output logic [1:0]      rx_store
);
    // registered so each pulse starts just after an edge
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rx_store <= 2'h0;
        else
            rx_store <= msg_rdy;
    end
endmodule : crf_rx_model
`default_nettype wire

// >>> bench/crf_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module crf_top_checker
    import crf_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        nrst,
    // register port
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    // fifo side
    input wire logic [1:0]  rx_store,
    input wire logic [1:0]  fifo_irq,
    input wire logic [1:0]  release_done
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////////
    // read data and reserved bits
    property p_f0_rsv; rd && addr == CRF_OFS_FIFO0 |=> rdata[31:6] == 26'h0 && !rdata[2]; endproperty
    a_f0_rsv: assert property (p_f0_rsv) else $error("fifo0 reserved bit set");
    property p_f1_rsv; rd && addr == CRF_OFS_FIFO1 |=> rdata[31:6] == 26'h0 && !rdata[2]; endproperty
    a_f1_rsv: assert property (p_f1_rsv) else $error("fifo1 reserved bit set");
    property p_ier_rsv; rd && addr == CRF_OFS_IRQ_EN |=> (rdata & ~CRF_IRQ_EN_MASK) == 32'h0; endproperty
    a_ier_rsv: assert property (p_ier_rsv) else $error("enable reserved bit set");
    // release pulses follow a release write
    property p_rel0; release_done[0] |-> $past(wr) && $past(addr) == CRF_OFS_FIFO0; endproperty
    a_rel0: assert property (p_rel0) else $error("fifo0 freed without request");
    property p_rel1; release_done[1] |-> $past(wr) && $past(addr) == CRF_OFS_FIFO1; endproperty
    a_rel1: assert property (p_rel1) else $error("fifo1 freed without request");
    property p_rel_once; release_done[0] |=> !release_done[0]; endproperty
    a_rel_once: assert property (p_rel_once) else $error("release bit not cleared");
    // interrupt moves only after its causes
    property p_irq_up; $rose(fifo_irq[0]) |-> $past(rx_store[0], 2) || $past(wr, 2); endproperty
    a_irq_up: assert property (p_irq_up) else $error("irq rose without cause");
    property p_irq_dn; $fell(fifo_irq[0]) |-> $past(wr, 2) || $past(wr, 3); endproperty
    a_irq_dn: assert property (p_irq_dn) else $error("irq fell without write");
endmodule : crf_top_checker
bind crf_top crf_top_checker u_chk (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata,
    .rx_store, .fifo_irq, .release_done);
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import crf_pkg::*;
;
    logic        clk = 0, nrst = 0, wr = 0, rd = 0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  msg_rdy = 2'h0, rx_store, fifo_irq, release_done;
    int          miscompares = 0, num_checks = 0, cycles = 0;
    always #12.5 clk = ~clk;
    crf_rx_model u_rx (.clk, .nrst, .msg_rdy, .rx_store);
    crf_top dut (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .rx_store, .fifo_irq,
        .release_done);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check("rdata", rdata, exp);
    endtask : rd_chk
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask : settle
    task automatic store(input int g, input int n);
        repeat (n)
        begin
            @(posedge clk);
            msg_rdy[g] <= 1'b1;
            @(posedge clk);
            msg_rdy[g] <= 1'b0;
        end
        settle();
    endtask : store
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_fifo(input int g);
        logic [7:0] ofs;
        ofs = g ? CRF_OFS_FIFO1 : CRF_OFS_FIFO0;
        store(g, 3);
        rd_chk(ofs, 32'h0B);
        store(g, 1);
        rd_chk(ofs, 32'h1B);
        for (int k = 2; k >= 0; k--)
        begin
            wr_reg(ofs, 32'h20);
            check("freed", release_done[g], 1'b1);
            rd_chk(ofs, 32'h18 | k);
        end
        wr_reg(ofs, 32'hFFFFFFFF);
        check("freed", release_done[g], 1'b0);
        rd_chk(ofs, 32'h0);
    endtask : t_fifo
    task automatic t_irq();
        wr_reg(CRF_OFS_IRQ_EN, 32'hFFFFFFFF);
        rd_chk(CRF_OFS_IRQ_EN, CRF_IRQ_EN_MASK);
        wr_reg(CRF_OFS_IRQ_EN, 32'h08);
        store(0, 3);
        check("irq", fifo_irq, 2'h0);
        store(0, 1);
        check("irq", fifo_irq, 2'h1);
        wr_reg(CRF_OFS_FIFO0, 32'h18);
        settle();
        check("irq", fifo_irq, 2'h0);
        wr_reg(CRF_OFS_IRQ_EN, 32'h10);
        store(1, 1);
        check("irq", fifo_irq, 2'h2);
        wr_reg(CRF_OFS_FIFO1, 32'h20);
        settle();
        check("irq", fifo_irq, 2'h0);
    endtask : t_irq
    task automatic t_swap();
        wr_reg(CRF_OFS_IRQ_EN, 32'h02);
        settle();
        check("irq", fifo_irq, 2'h1);
        @(posedge clk);
        addr <= CRF_OFS_FIFO0;
        wdata <= 32'h20;
        wr <= 1'b1;
        msg_rdy <= 2'h1;
        @(posedge clk);
        wr <= 1'b0;
        msg_rdy <= 2'h0;
        #1 check("freed", release_done[0], 1'b1);
        settle();
        rd_chk(CRF_OFS_FIFO0, 32'h03);
        for (int k = 2; k >= 0; k--)
        begin
            wr_reg(CRF_OFS_FIFO0, 32'h20);
            check("freed", release_done[0], 1'b1);
        end
        rd_chk(CRF_OFS_FIFO0, 32'h00);
        settle();
        check("irq", fifo_irq, 2'h0);
    endtask : t_swap
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////////////
    // hang guard
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            miscompares++;
            close_out();
        end
    end
    // main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(CRF_OFS_IRQ_EN, 32'h0);
        rd_chk(8'h18, 32'h0);
        t_fifo(0);
        t_fifo(1);
        t_irq();
        t_swap();
        close_out();
    end
endmodule : testbench
`default_nettype wire
